// *** hw/srap_params.svh ***
// constants of the serial register access port
// assumes inclusion by the package and the design modules
`ifndef SRAP_PARAMS_SVH
`define SRAP_PARAMS_SVH

// register map geometry
`define SRAP_AW 6
`define SRAP_DW 24
`define SRAP_NREG 64
`define SRAP_REG_RESET 24'h000000

// spi frame bit counter marks (value after the n-th rising edge)
`define SRAP_CNT_W 6
`define SRAP_CNT_ADDR 6'h06
`define SRAP_CNT_DATA 6'h08
`define SRAP_CNT_LAST 6'h20

// i2c slave address, upper six bits fixed
`define SRAP_I2C_ID_HI 6'h04
`define SRAP_I2C_BYTE_END 4'h8
`define SRAP_I2C_TX_LAST 4'h7
`define SRAP_I2C_WR_LAST 2'h3
`define SRAP_I2C_RD_LAST 2'h2

// strap settle cycles after reset release
`define SRAP_INIT_CYC 2'h3

`endif

// *** hw/srap_pkg.sv ***
// types shared by the serial register access port
// assumes srap_params.svh is reachable on the include path
`include "srap_params.svh"

package srap_pkg;

    // interface personality caught at cold start
    typedef enum logic {
        SRAP_MODE_SPI,
        SRAP_MODE_I2C
    } srap_mode_t;

    // decoded frame header
    typedef struct packed {
        logic wr;
        logic [`SRAP_AW-1:0] addr;
    } srap_cmd_t;

    // register write request
    typedef struct packed {
        logic [`SRAP_AW-1:0] addr;
        logic [`SRAP_DW-1:0] data;
    } srap_wr_t;

    // i2c slave sequencing
    typedef enum logic [2:0] {
        SRAP_I_IDLE,
        SRAP_I_DEV,
        SRAP_I_DACK,
        SRAP_I_RX,
        SRAP_I_RACK,
        SRAP_I_TX,
        SRAP_I_TACK,
        SRAP_I_TLD
    } srap_i2c_state_t;

endpackage

// *** hw/srap_i2c_slave.sv ***
// i2c slave engine of the serial register access port
// assumes scl and sda already synchronised to clk_i by the caller
`timescale 1ns/1ps
`include "srap_params.svh"

module srap_i2c_slave (
    // system
    input wire logic clk_i,
    input wire logic reset_n_i,
    // configuration
    input wire logic en_i,
    input wire logic sel_i,
    // synchronised bus levels
    input wire logic scl_i,
    input wire logic sda_i,
    // register side
    input wire logic [`SRAP_DW-1:0] rd_data_i,
    output logic rd_req_o,
    output logic wr_req_o,
    output srap_pkg::srap_wr_t wr_o,
    output logic sda_oe_o
);

    srap_pkg::srap_i2c_state_t state, next_state;
    logic [3:0] cnt, next_cnt;
    logic [7:0] sh, next_sh;
    logic [1:0] idx, next_idx;
    logic rw, next_rw;
    logic scl_q, sda_q;
    logic next_oe, next_rd, next_wr;
    srap_pkg::srap_wr_t next_wo;
    logic scl_r, scl_f, start, stop;

    // bus conditions from the previous sampled levels
    assign scl_r = scl_i & ~scl_q;
    assign scl_f = ~scl_i & scl_q;
    assign start = scl_i & scl_q & sda_q & ~sda_i;
    assign stop = scl_i & scl_q & ~sda_q & sda_i;

    // next state; start and stop override any bit activity
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_sh = sh;
        next_idx = idx;
        next_rw = rw;
        next_oe = sda_oe_o;
        next_wo = wr_o;
        next_rd = 1'b0;
        next_wr = 1'b0;
        if (!en_i) begin
            next_state = srap_pkg::SRAP_I_IDLE;
            next_oe = 1'b0;
        end else if (start) begin
            next_state = srap_pkg::SRAP_I_DEV;
            next_cnt = 4'h0;
            next_idx = 2'h0;
            next_oe = 1'b0;
        end else if (stop) begin
            // a short write simply never reaches the commit
            next_state = srap_pkg::SRAP_I_IDLE;
            next_oe = 1'b0;
        end else if (scl_r) begin
            unique case (state)
                srap_pkg::SRAP_I_DEV, srap_pkg::SRAP_I_RX: begin
                    next_sh = {sh[6:0], sda_i};
                    next_cnt = cnt + 4'h1;
                end
                srap_pkg::SRAP_I_TACK: begin
                    if (sda_i || idx == `SRAP_I2C_RD_LAST) begin
                        next_state = srap_pkg::SRAP_I_IDLE;
                    end else begin
                        next_state = srap_pkg::SRAP_I_TLD;
                    end
                end
                srap_pkg::SRAP_I_IDLE, srap_pkg::SRAP_I_DACK,
                srap_pkg::SRAP_I_RACK, srap_pkg::SRAP_I_TX,
                srap_pkg::SRAP_I_TLD: begin
                end
            endcase
        end else if (scl_f) begin
            unique case (state)
                srap_pkg::SRAP_I_DEV: begin
                    if (cnt == `SRAP_I2C_BYTE_END) begin
                        next_cnt = 4'h0;
                        // slave only, one of two addresses
                        if (sh[7:1] == {`SRAP_I2C_ID_HI, sel_i}) begin
                            next_state = srap_pkg::SRAP_I_DACK;
                            next_oe = 1'b1;
                            next_rw = sh[0];
                            next_rd = sh[0];
                        end else begin
                            next_state = srap_pkg::SRAP_I_IDLE;
                        end
                    end
                end
                srap_pkg::SRAP_I_DACK: begin
                    if (rw) begin
                        next_wo.data = rd_data_i;
                        next_oe = ~rd_data_i[`SRAP_DW-1];
                        next_state = srap_pkg::SRAP_I_TX;
                    end else begin
                        next_oe = 1'b0;
                        next_state = srap_pkg::SRAP_I_RX;
                    end
                end
                srap_pkg::SRAP_I_RX: begin
                    if (cnt == `SRAP_I2C_BYTE_END) begin
                        next_cnt = 4'h0;
                        next_oe = 1'b1;
                        next_state = srap_pkg::SRAP_I_RACK;
                        if (idx == 2'h0) begin
                            next_wo.addr = sh[`SRAP_AW-1:0];
                        end else begin
                            next_wo.data = {wr_o.data[15:0], sh};
                        end
                    end
                end
                srap_pkg::SRAP_I_RACK: begin
                    next_oe = 1'b0;
                    next_state = srap_pkg::SRAP_I_RX;
                    // commit only as the third data ack ends
                    if (idx == `SRAP_I2C_WR_LAST) begin
                        next_wr = 1'b1;
                        next_idx = 2'h1;
                    end else begin
                        next_idx = idx + 2'h1;
                    end
                end
                srap_pkg::SRAP_I_TX: begin
                    next_cnt = cnt + 4'h1;
                    next_wo.data = {wr_o.data[`SRAP_DW-2:0], 1'b0};
                    if (cnt == `SRAP_I2C_TX_LAST) begin
                        next_oe = 1'b0;
                        next_state = srap_pkg::SRAP_I_TACK;
                    end else begin
                        next_oe = ~wr_o.data[`SRAP_DW-2];
                    end
                end
                srap_pkg::SRAP_I_TLD: begin
                    next_idx = idx + 2'h1;
                    next_cnt = 4'h0;
                    next_oe = ~wr_o.data[`SRAP_DW-1];
                    next_state = srap_pkg::SRAP_I_TX;
                end
                srap_pkg::SRAP_I_IDLE, srap_pkg::SRAP_I_TACK: begin
                end
            endcase
        end
    end

    // state registers
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= srap_pkg::SRAP_I_IDLE;
            cnt <= 4'h0;
            sh <= 8'h00;
            idx <= 2'h0;
            rw <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            sda_oe_o <= 1'b0;
            rd_req_o <= 1'b0;
            wr_req_o <= 1'b0;
            wr_o <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            sh <= next_sh;
            idx <= next_idx;
            rw <= next_rw;
            scl_q <= scl_i;
            sda_q <= sda_i;
            sda_oe_o <= next_oe;
            rd_req_o <= next_rd;
            wr_req_o <= next_wr;
            wr_o <= next_wo;
        end
    end

endmodule

// *** hw/srap_top.sv ***
// serial register access port: spi or i2c slave onto a 64 x 24 map
// assumes sclk_i is the host's serial clock and may stop between frames
//
// Contract
// - latch chip select level at cold start
// - i2c reuses clock and output pins
// - input pin level picks i2c address
// - frame is flag, address, null, data
// - six address bits select 64 registers
// - sample header bits on rising clock
// - drive 24 data bits on falling edges
// - read leaves addressed register unchanged except cor bits, which it clears
// - write commits on 32nd falling edge
// - write frame shifts out current read data
// - early select drop abandons the frame
// - output tristated while select is low
// - per-bit rw, ro, w1c, cor, unused
// - address field and unused read zero
// - i2c commits at third data ack
// - i2c slave answers fixed address plus strap
`timescale 1ns/1ps
`include "srap_params.svh"

module srap_top #(
    parameter logic [`SRAP_NREG-1:0][`SRAP_DW-1:0] RW_MASK = '1,
    parameter logic [`SRAP_NREG-1:0][`SRAP_DW-1:0] RO_MASK = '0,
    parameter logic [`SRAP_NREG-1:0][`SRAP_DW-1:0] W1C_MASK = '0,
    parameter logic [`SRAP_NREG-1:0][`SRAP_DW-1:0] COR_MASK = '0
) (
    // system
    input wire logic clk_i,
    input wire logic reset_n_i,
    // serial pins
    input wire logic sclk_i,
    input wire logic cs_i,
    input wire logic sdi_i,
    input wire logic sda_i,
    output logic spi_out_o,
    output logic spi_oe_o,
    output logic sda_out_o,
    output logic sda_oe_o,
    // hardware status updates
    input wire logic hw_we_i,
    input wire logic [`SRAP_AW-1:0] hw_addr_i,
    input wire logic [`SRAP_DW-1:0] hw_data_i,
    // core view of the map
    input wire logic [`SRAP_AW-1:0] core_addr_i,
    output logic [`SRAP_DW-1:0] core_data_o,
    output logic wr_strobe_o,
    output logic [`SRAP_AW-1:0] wr_addr_o,
    output logic mode_i2c_o
);

    localparam logic [`SRAP_NREG-1:0][`SRAP_DW-1:0] VIS =
        RW_MASK | RO_MASK | W1C_MASK | COR_MASK;
    localparam logic [`SRAP_NREG-1:0][`SRAP_DW-1:0] OVL =
        (RW_MASK & (RO_MASK | W1C_MASK | COR_MASK)) |
        (RO_MASK & (W1C_MASK | COR_MASK)) | (W1C_MASK & COR_MASK);

    // a bit can carry only one access kind
    if (OVL != '0) begin : g_mask_check
        $error("srap_top: bit attribute masks overlap");
    end

    // ---------------- core domain: pins and strap ----------------
    logic [3:0] pin_meta, pin_sync;
    logic cs_s, sdi_s, scl_s, sda_s;
    logic [1:0] init_cnt, next_init_cnt;
    logic init_done, next_init_done;
    srap_pkg::srap_mode_t mode, next_mode;
    logic addr_sel, next_addr_sel;
    logic spi_en;

    assign cs_s = pin_sync[0];
    assign sdi_s = pin_sync[1];
    assign scl_s = pin_sync[2];
    assign sda_s = pin_sync[3];
    assign spi_en = init_done & (mode == srap_pkg::SRAP_MODE_SPI);

    // two-stage synchronisers for every pin seen by clk_i
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
        end else begin
            pin_meta <= {sda_i, sclk_i, sdi_i, cs_i};
            pin_sync <= pin_meta;
        end
    end

    // strap capture waits for the synchronisers to fill
    always_comb begin
        next_init_cnt = init_cnt;
        next_init_done = init_done;
        next_mode = mode;
        next_addr_sel = addr_sel;
        if (!init_done) begin
            if (init_cnt == `SRAP_INIT_CYC) begin
                next_init_done = 1'b1;
                next_mode = cs_s ? srap_pkg::SRAP_MODE_I2C
                                 : srap_pkg::SRAP_MODE_SPI;
                next_addr_sel = sdi_s;
            end else begin
                next_init_cnt = init_cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            init_cnt <= 2'h0;
            init_done <= 1'b0;
            mode <= srap_pkg::SRAP_MODE_SPI;
            addr_sel <= 1'b0;
        end else begin
            init_cnt <= next_init_cnt;
            init_done <= next_init_done;
            mode <= next_mode;
            addr_sel <= next_addr_sel;
        end
    end

    // ---------------- link domain: spi frame ----------------
    logic link_rst_n;
    logic [`SRAP_CNT_W-1:0] cnt, next_cnt;
    logic [30:0] sr, next_sr;
    srap_pkg::srap_cmd_t cmd, next_cmd;
    logic rd_tog, next_rd_tog;
    logic [`SRAP_DW-1:0] out_sr, next_out_sr, rd_hold;
    logic next_spi_out, done, next_done;
    srap_pkg::srap_wr_t lwr, next_lwr;
    logic wr_tog, next_wr_tog;

    // select low clears the frame asynchronously
    assign link_rst_n = reset_n_i & cs_i & spi_en;

    // rising edge: shift in header and data, decode address
    always_comb begin
        next_cnt = cnt;
        next_sr = sr;
        next_cmd = cmd;
        next_rd_tog = rd_tog;
        if (cnt != `SRAP_CNT_LAST) begin
            next_cnt = cnt + 6'h01;
            next_sr = {sr[29:0], sdi_i};
        end
        // 7th bit completes the address; dead bit covers the lookup
        if (cnt == `SRAP_CNT_ADDR) begin
            next_cmd.wr = sr[5];
            next_cmd.addr = {sr[4:0], sdi_i};
            next_rd_tog = ~rd_tog;
        end
    end

    always_ff @(posedge sclk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            cnt <= '0;
            sr <= '0;
        end else begin
            cnt <= next_cnt;
            sr <= next_sr;
        end
    end

    // header and toggle survive select edges so no event is faked
    always_ff @(posedge sclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cmd <= '0;
            rd_tog <= 1'b0;
        end else begin
            cmd <= next_cmd;
            rd_tog <= next_rd_tog;
        end
    end

    // falling edge: data out, write commit on the 32nd edge
    always_comb begin
        next_out_sr = out_sr;
        next_spi_out = 1'b0;
        next_done = done;
        next_lwr = lwr;
        next_wr_tog = wr_tog;
        if (cnt == `SRAP_CNT_DATA) begin
            next_spi_out = rd_hold[`SRAP_DW-1];
            next_out_sr = {rd_hold[`SRAP_DW-2:0], 1'b0};
        end else if (cnt > `SRAP_CNT_DATA && cnt < `SRAP_CNT_LAST) begin
            next_spi_out = out_sr[`SRAP_DW-1];
            next_out_sr = {out_sr[`SRAP_DW-2:0], 1'b0};
        end else if (cnt == `SRAP_CNT_LAST && !done) begin
            next_done = 1'b1;
            // a read frame never raises the write toggle
            if (cmd.wr) begin
                next_lwr.addr = cmd.addr;
                next_lwr.data = sr[`SRAP_DW-1:0];
                next_wr_tog = ~wr_tog;
            end
        end
    end

    always_ff @(negedge sclk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            out_sr <= '0;
            spi_out_o <= 1'b0;
            done <= 1'b0;
        end else begin
            out_sr <= next_out_sr;
            spi_out_o <= next_spi_out;
            done <= next_done;
        end
    end

    always_ff @(negedge sclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lwr <= '0;
            wr_tog <= 1'b0;
        end else begin
            lwr <= next_lwr;
            wr_tog <= next_wr_tog;
        end
    end

    // ---------------- crossing back to clk_i ----------------
    logic [1:0] tog_meta, tog_sync, tog_prev;
    logic rd_ev, wr_ev;

    // toggles pass two flops; the third only feeds edge detection
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tog_meta <= 2'h0;
            tog_sync <= 2'h0;
            tog_prev <= 2'h0;
        end else begin
            tog_meta <= {wr_tog, rd_tog};
            tog_sync <= tog_meta;
            tog_prev <= tog_sync;
        end
    end

    assign rd_ev = spi_en & (tog_sync[0] ^ tog_prev[0]);
    assign wr_ev = spi_en & (tog_sync[1] ^ tog_prev[1]);

    // ---------------- i2c personality ----------------
    logic i2c_en, i2c_rd, i2c_wr;
    srap_pkg::srap_wr_t i2c_w;

    assign i2c_en = init_done & (mode == srap_pkg::SRAP_MODE_I2C);

    // clock pin is scl, output pin is sda
    srap_i2c_slave u_i2c (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .en_i(i2c_en),
        .sel_i(addr_sel),
        .scl_i(scl_s),
        .sda_i(sda_s),
        .rd_data_i(rd_hold),
        .rd_req_o(i2c_rd),
        .wr_req_o(i2c_wr),
        .wr_o(i2c_w),
        .sda_oe_o(sda_oe_o)
    );

    // ---------------- register map ----------------
    logic [`SRAP_DW-1:0] regs [`SRAP_NREG];
    logic [`SRAP_DW-1:0] next_regs [`SRAP_NREG];
    logic [`SRAP_DW-1:0] next_hold;
    logic rd_go, wr_go;
    logic [`SRAP_AW-1:0] rd_addr;
    srap_pkg::srap_wr_t wsel;

    assign rd_go = rd_ev | i2c_rd;
    assign rd_addr = i2c_en ? i2c_w.addr : cmd.addr;
    assign wr_go = wr_ev | i2c_wr;
    assign wsel = i2c_en ? i2c_w : lwr;

    // host write, clear on read, then hardware set so a set wins
    always_comb begin
        next_regs = regs;
        if (wr_go) begin
            next_regs[wsel.addr] = (regs[wsel.addr] & ~RW_MASK[wsel.addr]
                & ~(W1C_MASK[wsel.addr] & wsel.data))
                | (wsel.data & RW_MASK[wsel.addr]);
        end
        if (rd_go) begin
            next_regs[rd_addr] = next_regs[rd_addr]
                & ~COR_MASK[rd_addr];
        end
        if (hw_we_i) begin
            next_regs[hw_addr_i] = (next_regs[hw_addr_i]
                & ~RO_MASK[hw_addr_i])
                | (hw_data_i & RO_MASK[hw_addr_i])
                | (hw_data_i & (W1C_MASK[hw_addr_i]
                | COR_MASK[hw_addr_i]));
        end
    end

    // read word held still for the link side to pick up
    always_comb begin
        next_hold = rd_hold;
        if (rd_go) begin
            next_hold = regs[rd_addr] & VIS[rd_addr];
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < `SRAP_NREG; i++) begin
                regs[i] <= `SRAP_REG_RESET;
            end
            rd_hold <= '0;
        end else begin
            regs <= next_regs;
            rd_hold <= next_hold;
        end
    end

    // ---------------- registered outputs ----------------
    // output enable drops the instant select falls
    always_ff @(posedge clk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            spi_oe_o <= 1'b0;
        end else begin
            spi_oe_o <= cs_s;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sda_out_o <= 1'b0;
            core_data_o <= '0;
            wr_strobe_o <= 1'b0;
            wr_addr_o <= '0;
            mode_i2c_o <= 1'b0;
        end else begin
            sda_out_o <= 1'b0;
            core_data_o <= regs[core_addr_i] & VIS[core_addr_i];
            wr_strobe_o <= wr_go;
            wr_addr_o <= wr_go ? wsel.addr : wr_addr_o; // held between commits
            mode_i2c_o <= i2c_en;
        end
    end

endmodule

// *** tb/srap_monitor.sv ***
// checker for the serial register access port, spi personality
// assumes it is bound onto srap_top and sees only its ports
`timescale 1ns/1ps
`include "srap_params.svh"

module srap_monitor (
    // system
    input wire logic clk_i,
    input wire logic reset_n_i,
    // serial pins
    input wire logic sclk_i,
    input wire logic cs_i,
    input wire logic spi_out_o,
    input wire logic spi_oe_o,
    input wire logic sda_out_o,
    input wire logic sda_oe_o,
    // commit side
    input wire logic wr_strobe_o,
    input wire logic [`SRAP_AW-1:0] wr_addr_o,
    input wire logic mode_i2c_o
);
    logic [5:0] rise_cnt;
    logic [5:0] next_rise_cnt;

    // rises seen in this frame, saturating so long frames stay sane
    always_comb begin
        next_rise_cnt = rise_cnt;
        if (rise_cnt != 6'h3F) begin
            next_rise_cnt = rise_cnt + 6'h01;
        end
    end

    // select low clears it, same as the frame logic
    always_ff @(posedge sclk_i or negedge cs_i) begin
        if (!cs_i) begin
            rise_cnt <= 6'h00;
        end else begin
            rise_cnt <= next_rise_cnt;
        end
    end

    // link side: header bits answered with zero, data bits driven
    AST_HDR_ZERO: assert property (@(posedge sclk_i)
        disable iff (!reset_n_i || !cs_i || mode_i2c_o)
        (rise_cnt < 6'h08) |-> !spi_out_o) else $error("header not zero");
    AST_OE_DATA: assert property (@(posedge sclk_i)
        disable iff (!reset_n_i || !cs_i || mode_i2c_o)
        (rise_cnt >= 6'h08) |-> spi_oe_o) else $error("data not driven");

    // core side
    AST_OE_OFF: assert property (@(posedge clk_i)
        disable iff (!reset_n_i) !cs_i |-> !spi_oe_o)
        else $error("output driven with select low");
    AST_MODE_OE: assert property (@(posedge clk_i)
        disable iff (!reset_n_i) mode_i2c_o |-> !spi_oe_o)
        else $error("spi drive in i2c mode");
    AST_SDA_SPI: assert property (@(posedge clk_i)
        disable iff (!reset_n_i) !mode_i2c_o |-> !sda_oe_o && !sda_out_o)
        else $error("sda in spi mode");
    AST_STROBE_PULSE: assert property (@(posedge clk_i)
        disable iff (!reset_n_i) wr_strobe_o |=> !wr_strobe_o)
        else $error("strobe longer than one");
    AST_ADDR_HOLD: assert property (@(posedge clk_i)
        disable iff (!reset_n_i) $changed(wr_addr_o) |-> wr_strobe_o)
        else $error("address moved alone");
    AST_STROBE_FRAME: assert property (@(posedge clk_i)
        disable iff (!reset_n_i) wr_strobe_o |-> cs_i)
        else $error("commit outside a frame");

    // main scenarios reached
    COV_COMMIT: cover property (@(posedge clk_i) wr_strobe_o);
    COV_FULL: cover property (@(posedge sclk_i) rise_cnt == 6'h1F);
    COV_DRIVE: cover property (@(posedge clk_i) !mode_i2c_o && spi_oe_o);
endmodule

bind srap_top srap_monitor mon_u (
    .clk_i, .reset_n_i, .sclk_i, .cs_i, .spi_out_o, .spi_oe_o,
    .sda_out_o, .sda_oe_o, .wr_strobe_o, .wr_addr_o, .mode_i2c_o
);

// *** tb/srap_host.sv ***
// behavioural spi host driving framed 32-bit words
// assumes the bench resolves the output pin and calls xfer
`timescale 1ns/1ps

module srap_host (
    // link pins toward the port
    output logic sclk_o,
    output logic cs_o,
    output logic sdi_o,
    input wire logic miso_i,
    // read word of the last full frame
    output logic [23:0] rd_o,
    output logic rd_vld_o
);
    // clock stands low between frames
    initial begin
        sclk_o = 1'b0;
        cs_o = 1'b0;
        sdi_o = 1'b0;
        rd_o = 24'h000000;
        rd_vld_o = 1'b0;
    end

    // one frame; fewer than 32 bits drops select early
    task automatic xfer(input logic [31:0] word, input int nbits);
        logic [23:0] rd;
        rd = 24'h000000;
        cs_o = 1'b1;
        #15;
        for (int i = 0; i < nbits; i++) begin
            sdi_o = word[31-i];
            #6 sclk_o = 1'b1;
            if (i >= 8) rd = {rd[22:0], miso_i};
            #6 sclk_o = 1'b0;
        end
        #40;
        cs_o = 1'b0;
        sdi_o = ~sdi_o; // line inverted, stale value not kept
        if (nbits == 32) begin
            // word settles before the strobe that announces it
            rd_o = rd;
            #1 rd_vld_o = 1'b1;
            #1 rd_vld_o = 1'b0;
        end
        #16;
    endtask

    // select level seen at a cold start picks the personality
    task automatic strap(input logic lvl);
        cs_o = lvl;
    endtask
endmodule

// *** tb/srap_top_bench.sv ***
// self-checking bench of srap_top in spi personality
// assumes srap_host as the far side and srap_monitor bound on the top
`timescale 1ns/1ps
`include "srap_params.svh"

module srap_top_bench;
    logic clk_i, reset_n_i, hw_we_i;
    logic [5:0] hw_addr_i, core_addr_i;
    logic [23:0] hw_data_i;
    wire logic sclk, cs, sdi, miso, sda_lvl, rd_vld;
    wire logic [23:0] rd_word, core_data_o;
    wire logic spi_out_o, spi_oe_o, sda_out_o, sda_oe_o;
    wire logic wr_strobe_o, mode_i2c_o;
    wire logic [5:0] wr_addr_o;
    logic [23:0] mem [64];
    logic [23:0] exp_rd[$];
    logic [23:0] exp_core[$];
    logic [5:0] exp_wa[$];
    int err_count = 0;
    int tests_run = 0;
    event core_go;

    // pad: one enable drives, otherwise the pull-up wins
    assign miso = spi_oe_o ? spi_out_o : (sda_oe_o ? sda_out_o : 1'bz);
    assign sda_lvl = (spi_oe_o | sda_oe_o) ? miso : 1'b1;

    srap_top dut_u (.clk_i, .reset_n_i, .sclk_i(sclk), .cs_i(cs),
        .sdi_i(sdi), .sda_i(sda_lvl), .spi_out_o, .spi_oe_o, .sda_out_o,
        .sda_oe_o, .hw_we_i, .hw_addr_i, .hw_data_i, .core_addr_i,
        .core_data_o, .wr_strobe_o, .wr_addr_o, .mode_i2c_o);
    srap_host host_u (.sclk_o(sclk), .cs_o(cs), .sdi_o(sdi),
        .miso_i(miso), .rd_o(rd_word), .rd_vld_o(rd_vld));

    // 250 MHz core clock
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic chk_word(input string what, input logic [23:0] e, g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk_addr(input string what, input logic [5:0] e, g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // note expectations, then send; short frames expect nothing
    task automatic frame(input logic wr, input logic [5:0] a,
                         input logic [23:0] d, input int nbits);
        if (nbits == 32) exp_rd.push_back(mem[a]);
        if (nbits == 32 && wr) begin
            exp_wa.push_back(a);
            mem[a] = d;
        end
        host_u.xfer({wr, a, 1'b0, d}, nbits);
    endtask

    task automatic core_chk(input logic [5:0] a);
        @(negedge clk_i);
        core_addr_i = a;
        exp_core.push_back(mem[a]);
        -> core_go;
    endtask

    // result watchers take the oldest note
    always @(posedge rd_vld)
        chk_word("read word", exp_rd.pop_front(), rd_word);
    always @(negedge clk_i)
        if (wr_strobe_o === 1'b1)
            chk_addr("write address", exp_wa.pop_front(), wr_addr_o);
    always @(core_go) begin
        repeat (2) @(negedge clk_i);
        chk_word("core data", exp_core.pop_front(), core_data_o);
    end

    // hang guard, far above the expected 18 us
    initial begin
        #100000;
        err_count++;
        close_out();
    end

    // main sequence
    initial begin
        logic [5:0] a;
        logic [23:0] d;
        void'($urandom(63247));
        reset_n_i = 1'b0;
        hw_we_i = 1'b0;
        hw_addr_i = 6'h00;
        hw_data_i = 24'h000000;
        core_addr_i = 6'h00;
        foreach (mem[i]) mem[i] = 24'h000000;
        repeat (16) @(negedge clk_i);
        reset_n_i = 1'b1;
        repeat (10) @(negedge clk_i);
        chk_word("mode", 24'h000000, {23'h0, mode_i2c_o});
        for (int i = 0; i < 8; i++) begin
            a = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : 6'($urandom);
            d = 24'($urandom);
            frame(1'b1, a, d, 32);
            frame(1'b0, a, 24'($urandom), 32);
            frame(1'b0, a, 24'hFFFFFF, 32);
            // hardware update must leave host-owned bits alone
            @(negedge clk_i);
            hw_addr_i = a;
            hw_data_i = 24'($urandom);
            hw_we_i = 1'b1;
            @(negedge clk_i);
            hw_we_i = 1'b0;
            core_chk(a);
            frame(1'b1, a, ~d, (i == 7) ? 31 : 20 + i);
            frame(1'b0, a, 24'h000000, 32);
        end
        repeat (20) @(negedge clk_i);
        chk_addr("pending strobes", 6'h00, 6'(exp_wa.size()));
        // second cold start with select strapped high
        @(negedge clk_i);
        reset_n_i = 1'b0;
        host_u.strap(1'b1);
        repeat (4) @(negedge clk_i);
        reset_n_i = 1'b1;
        repeat (10) @(negedge clk_i);
        chk_word("i2c mode", 24'h000001, {23'h0, mode_i2c_o});
        chk_word("pin drive", 24'h000000,
            {21'h0, sda_out_o, sda_oe_o, spi_oe_o});
        close_out();
    end
endmodule
